// >>> sim/ftm_fan_partner.sv
// Far-side model: two fan tach outputs and the external intrusion latch.
// Assumes the bench supplies the tach periods in clock cycles; 0 stops a fan.
`timescale 1ns/100ps
module ftm_fan_partner (
    input  wire logic        i_ref_clk,
    input  wire logic [15:0] i_period_a,
    input  wire logic [15:0] i_period_b,
    input  wire logic        i_pin_out,
    input  wire logic        i_pin_oe,
    output logic             o_tach_a,
    output logic             o_tach_b,
    output logic             o_pin_level
);
    logic [15:0] cnt_a    = 16'h0000;
    logic [15:0] cnt_b    = 16'h0000;
    // Latched at power-up, as after an intrusion while the system was off
    logic        latch_ff = 1'b1;

    always @(negedge i_ref_clk) begin
        cnt_a <= (cnt_a + 16'h0001 >= i_period_a) ? 16'h0000 : cnt_a + 16'h0001;
        cnt_b <= (cnt_b + 16'h0001 >= i_period_b) ? 16'h0000 : cnt_b + 16'h0001;
        o_tach_a <= (i_period_a != 16'h0000) && (cnt_a < (i_period_a >> 1));
        o_tach_b <= (i_period_b != 16'h0000) && (cnt_b < (i_period_b >> 1));
        if (i_pin_oe && !i_pin_out) begin
            latch_ff <= 1'b0;
        end
    end

    // Open-drain node: device pull-down wins over the latch output
    assign o_pin_level = i_pin_oe ? i_pin_out : latch_ff;
endmodule

// >>> sim/tb_ftm_top.sv
// Self-checking bench for the fan tachometer monitor top.
// Assumes shortened tick and pulse parameters; inputs change on falling edges.
`timescale 1ns/100ps
module tb_ftm_top;
    logic        i_ref_clk = 1'b0;
    logic        i_rst_n = 1'b0;
    logic [7:0]  i_cfg = 8'h00;
    logic        i_div_wr = 1'b0;
    logic [7:0]  i_div_wdata = 8'h00;
    logic [7:0]  i_lim_a = 8'h24;
    logic [7:0]  i_lim_b = 8'h1C;
    logic [2:0]  i_mask = 3'h0;
    logic        i_stat_rd = 1'b0;
    logic        i_ciclr_wr = 1'b0;
    logic [7:0]  i_ciclr_wdata = 8'h00;
    logic [15:0] period_a = 16'h0140;
    logic [15:0] period_b = 16'h00C0;
    logic        tach_a, tach_b, pin_level, pin_out, pin_oe, o_int_n, o_analog_start;
    logic [7:0]  o_fan_a_val, o_fan_b_val, o_vid_div_rd, o_ciclr_rd;
    logic [2:0]  o_status;
    int          n_mismatch = 0;
    int          checks = 0;
    int          k;

    always #4 i_ref_clk = ~i_ref_clk;

    ftm_top #(.OSC_DIV_CYC(8), .ICL_PULSE_CYC(16)) u_ftm_top (
        .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_ce(1'b1), .i_cfg(i_cfg),
        .i_tach_input_a(tach_a), .i_tach_input_b(tach_b), .i_vid(4'hA),
        .i_div_wr(i_div_wr), .i_div_wdata(i_div_wdata), .i_lim_a(i_lim_a),
        .i_lim_b(i_lim_b), .i_mask(i_mask), .i_stat_rd(i_stat_rd),
        .i_ciclr_wr(i_ciclr_wr), .i_ciclr_wdata(i_ciclr_wdata),
        .i_intrusion_pin_in(pin_level), .o_intrusion_pin_out(pin_out),
        .o_intrusion_pin_oe(pin_oe), .o_fan_a_val(o_fan_a_val),
        .o_fan_b_val(o_fan_b_val), .o_status(o_status), .o_vid_div_rd(o_vid_div_rd),
        .o_ciclr_rd(o_ciclr_rd), .o_analog_start(o_analog_start), .o_int_n(o_int_n));

    ftm_fan_partner u_ftm_fan_partner (
        .i_ref_clk(i_ref_clk), .i_period_a(period_a), .i_period_b(period_b),
        .i_pin_out(pin_out), .i_pin_oe(pin_oe), .o_tach_a(tach_a),
        .o_tach_b(tach_b), .o_pin_level(pin_level));

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Tick phase against tach edges may move a count by one
    task automatic chk_near(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (!(got === exp || got === exp + 8'h01 || got === exp - 8'h01)) begin
            n_mismatch++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic div_write(input logic [7:0] d);
        @(negedge i_ref_clk);
        i_div_wr = 1'b1;
        i_div_wdata = d;
        @(negedge i_ref_clk);
        i_div_wr = 1'b0;
    endtask

    task automatic stat_read();
        @(negedge i_ref_clk);
        i_stat_rd = 1'b1;
        @(negedge i_ref_clk);
        i_stat_rd = 1'b0;
        @(negedge i_ref_clk);
    endtask

    task automatic ciclr_write(input logic [7:0] d);
        @(negedge i_ref_clk);
        i_ciclr_wr = 1'b1;
        i_ciclr_wdata = d;
        @(negedge i_ref_clk);
        i_ciclr_wr = 1'b0;
    endtask

    task automatic complete_run();
        if (n_mismatch == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        #(80000 * 8);
        n_mismatch++;
        complete_run();
    end

    initial begin
        repeat (2) @(negedge i_ref_clk);
        chk(o_vid_div_rd, 8'h5A);
        chk(o_fan_a_val, 8'h00);
        chk({5'h00, o_status}, 8'h00);
        chk({7'h00, o_int_n}, 8'h01);
        i_rst_n = 1'b1;
        repeat (2) @(negedge i_ref_clk);
        chk({5'h00, o_status}, 8'h04);
        chk({7'h00, o_int_n}, 8'h01);
        stat_read();
        chk({5'h00, o_status}, 8'h04);
        ciclr_write(8'h7F);
        chk({7'h00, pin_oe}, 8'h00);
        ciclr_write(8'h80);
        chk({7'h00, pin_oe}, 8'h01);
        chk(o_ciclr_rd, 8'h80);
        chk({7'h00, pin_out}, 8'h00);
        k = 0;
        while (pin_oe === 1'b1 && k < 40) begin
            k++;
            @(negedge i_ref_clk);
        end
        chk(8'(k >= 16 && k <= 17), 8'h01);
        chk(o_ciclr_rd, 8'h00);
        chk({7'h00, pin_level}, 8'h00);
        stat_read();
        chk({5'h00, o_status}, 8'h00);
        // Start monitoring: one analog start pulse within a few cycles
        i_cfg = 8'h03;
        k = 0;
        while (o_analog_start !== 1'b1 && k < 4) begin
            k++;
            @(negedge i_ref_clk);
        end
        chk({7'h00, o_analog_start}, 8'h01);
        @(negedge i_ref_clk);
        chk({7'h00, o_analog_start}, 8'h00);
        for (int n = 0; n < 4; n++) begin
            period_a = 16'(160 << n);
            period_b = 16'(96 << n);
            div_write({n[1:0], n[1:0], 4'h0});
            chk(o_vid_div_rd, {n[1:0], n[1:0], 4'hA});
            repeat (6 * (period_a + period_b) + 200) @(negedge i_ref_clk);
            chk_near(o_fan_a_val, 8'h28);
            chk_near(o_fan_b_val, 8'h18);
        end
        chk({5'h00, o_status}, 8'h01);
        chk({7'h00, o_int_n}, 8'h00);
        i_mask = 3'b001;
        @(negedge i_ref_clk);
        chk({7'h00, o_int_n}, 8'h01);
        i_mask = 3'b010;
        @(negedge i_ref_clk);
        chk({7'h00, o_int_n}, 8'h00);
        i_cfg = 8'h01;
        @(negedge i_ref_clk);
        chk({7'h00, o_int_n}, 8'h01);
        i_cfg = 8'h0B;
        @(negedge i_ref_clk);
        chk({7'h00, o_int_n}, 8'h01);
        // Slow fan a overflows, stopped fan b never gives an edge
        i_mask = 3'b000;
        i_lim_a = 8'hFE;
        i_lim_b = 8'hFE;
        period_a = 16'h07D0;
        period_b = 16'h0000;
        div_write(8'h00);
        i_cfg = 8'h03;
        repeat (16400) @(negedge i_ref_clk);
        chk(o_fan_a_val, 8'hFF);
        chk(o_fan_b_val, 8'hFF);
        chk({5'h00, o_status}, 8'h03);
        // Stopped: values hold and a read clears status for good
        i_cfg = 8'h00;
        stat_read();
        chk({5'h00, o_status}, 8'h00);
        period_a = 16'h0140;
        period_b = 16'h00C0;
        div_write(8'h50);
        repeat (3000) @(negedge i_ref_clk);
        chk(o_fan_a_val, 8'hFF);
        chk({5'h00, o_status}, 8'h00);
        complete_run();
    end
endmodule

// >>> src/ftm_meas_if.sv
// Carrier between the sequencer and the period measurement engine.
// Assumes both ends share one clock.
`timescale 1ns/100ps
interface ftm_meas_if;
    logic       go;
    logic       tick;
    logic       tach;
    logic [1:0] div;
    logic       done;
    logic [7:0] count;
    modport ctrl (output go, tick, tach, div, input done, count);
    modport meas (input go, tick, tach, div, output done, count);
endinterface

// >>> src/ftm_pkg.sv
// Constants shared by the fan tachometer monitor modules.
// Assumes a 125 MHz system clock with synchronous active-low reset.
// What this block does
// - Fan period is measured by counting 22.5 kHz ticks in an 8-bit counter.
// - Monitoring runs while the start bit is one and the output-clear bit is zero.
// - Counting starts on a tach rising edge and stops on the second following one.
// - Fans are measured in turn; each ends after two cycles or full scale.
// - Finished counts go to per-fan value outputs, refreshed while monitoring runs.
// - Prescaler divides ticks by 1, 2, 4 or 8; divide by 2 after reset.
// - Count equals 22500*60 over RPM times divisor, two pulses per revolution.
// - The counter saturates at 255 instead of wrapping.
// - Divisor codes sit in bits 4 to 7 of the register shared with VID inputs.
// - Fans have only an underspeed limit; status sets when count exceeds it.
// - Analog monitoring starts with fan monitoring, otherwise unsynchronised.
// - Intrusion pin is active high; a high level at power-up raises status.
// - Intrusion status stays set while the external latch stays set.
// - Writing bit 7 of intrusion clear drives the pin low 20 ms, then self-clears.
// - Each new value is compared; the result sets or clears its status bit.
// - A mask bit of one keeps its status bit off the interrupt; the status output still shows it.
// - Unmasked status bits are ORed onto the active-low interrupt output.
// - Interrupt active only while enable bit 1 is one and clear bit 3 zero.
// - Reading status returns it then clears it until the next update, except the intrusion bit while the pin is still high.
package ftm_pkg;
    localparam int unsigned CLK_HZ        = 125_000_000;
    localparam int unsigned OSC_HZ        = 22_500;
    localparam int unsigned OSC_DIV_CYC   = CLK_HZ / OSC_HZ;
    localparam int unsigned ICL_PULSE_MS  = 20;
    localparam int unsigned ICL_PULSE_CYC = (CLK_HZ / 1000) * ICL_PULSE_MS;
    localparam int          CFG_START_BIT = 0;
    localparam int          CFG_INTEN_BIT = 1;
    localparam int          CFG_ICLR_BIT  = 3;
    localparam int          CICLR_BIT     = 7;
    localparam int          DIV_A_LSB     = 4;
    localparam int          DIV_B_LSB     = 6;
    localparam logic [3:0]  DIV_RST       = 4'h5;
    localparam logic [7:0]  CNT_FULL      = 8'hFF;
    localparam logic [7:0]  CNT_LAST      = 8'hFE;
    localparam int          ST_FAN_A      = 0;
    localparam int          ST_FAN_B      = 1;
    localparam int          ST_INTR       = 2;
    localparam int          NUM_STAT      = 3;
endpackage

// >>> src/ftm_tach_meas.sv
// One tachometer period measurement with prescaler and saturation.
// Assumes tach is synchronous and go is a one-cycle pulse.
`timescale 1ns/100ps
module ftm_tach_meas (
    input  wire logic i_ref_clk,
    input  wire logic i_rst_n,
    input  wire logic i_ce,
    ftm_meas_if.meas  m
);
    typedef enum logic [2:0] {
        ME_IDLE = 3'b001,
        ME_WAIT = 3'b010,
        ME_CNT  = 3'b100
    } ftm_me_t;

    ftm_me_t    st_ff;
    logic [7:0] cnt_ff;
    logic [7:0] res_ff;
    logic [2:0] pre_ff;
    logic       edge_ff;
    logic       done_ff;
    logic       tach_q_ff;

    function automatic logic [2:0] div_top(input logic [1:0] code);
        div_top = 3'((4'h1 << code) - 4'h1);
    endfunction

    wire rise    = m.tach & ~tach_q_ff;
    wire pre_hit = m.tick && (pre_ff == div_top(m.div));
    wire sat_hit = pre_hit && (cnt_ff == ftm_pkg::CNT_LAST);

    assign m.done  = done_ff;
    assign m.count = res_ff;

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            st_ff     <= ME_IDLE;
            cnt_ff    <= 8'h00;
            res_ff    <= 8'h00;
            pre_ff    <= 3'h0;
            edge_ff   <= 1'b0;
            done_ff   <= 1'b0;
            tach_q_ff <= 1'b0;
        end else if (i_ce) begin
            done_ff   <= 1'b0;
            tach_q_ff <= m.tach;
            if (m.go) begin
                // Primed high: the new pin must be seen low first, so a mux switch is no edge
                st_ff     <= ME_WAIT;
                cnt_ff    <= 8'h00;
                pre_ff    <= 3'h0;
                edge_ff   <= 1'b0;
                tach_q_ff <= 1'b1;
            end else if (st_ff != ME_IDLE && rise && st_ff == ME_WAIT) begin
                st_ff  <= ME_CNT;
                cnt_ff <= 8'h00;
                pre_ff <= 3'h0;
            end else if (st_ff == ME_CNT && rise && edge_ff) begin
                st_ff   <= ME_IDLE;
                done_ff <= 1'b1;
                res_ff  <= cnt_ff;
            end else if (st_ff != ME_IDLE) begin
                if (rise) begin
                    edge_ff <= 1'b1;
                end
                if (sat_hit) begin
                    st_ff   <= ME_IDLE;
                    done_ff <= 1'b1;
                    res_ff  <= ftm_pkg::CNT_FULL;
                end else if (pre_hit) begin
                    cnt_ff <= 8'(cnt_ff + 8'h01);
                    pre_ff <= 3'h0;
                end else if (m.tick) begin
                    pre_ff <= 3'(pre_ff + 3'h1);
                end
            end
        end
    end

    property p_cnt_hold;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        (i_ce && st_ff == ME_CNT && !m.go && !rise && !pre_hit) |=> $stable(cnt_ff);
    endproperty
    a_cnt_hold: assert property (p_cnt_hold) else $error("count moved without tick");

    sequence s_open;
        i_ce && st_ff == ME_WAIT && rise && !m.go;
    endsequence
    property p_open;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        s_open |=> (st_ff == ME_CNT && cnt_ff == 8'h00 && !edge_ff);
    endproperty
    a_open: assert property (p_open) else $error("first edge did not start count");

    property p_close;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        (i_ce && st_ff == ME_CNT && edge_ff && rise && !m.go)
            |=> (done_ff && res_ff == $past(cnt_ff) && st_ff == ME_IDLE);
    endproperty
    a_close: assert property (p_close) else $error("third edge did not end count");

    property p_full;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        (i_ce && st_ff == ME_CNT && sat_hit && !(rise && edge_ff) && !m.go)
            |=> (done_ff && res_ff == 8'hFF);
    endproperty
    a_full: assert property (p_full) else $error("full scale did not end count");

    property p_noedge;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        (i_ce && st_ff == ME_WAIT && sat_hit && !rise && !m.go)
            |=> (done_ff && res_ff == 8'hFF) ##1 !done_ff;
    endproperty
    a_noedge: assert property (p_noedge) else $error("edgeless fan never ended");
endmodule

// >>> src/ftm_top.sv
// Fan tachometer monitor top: sequencer, limits, status, intrusion pin.
// Assumes all inputs are synchronous to i_ref_clk; register strobes are one-cycle.
`timescale 1ns/100ps
module ftm_top #(
    parameter int unsigned OSC_DIV_CYC   = ftm_pkg::OSC_DIV_CYC,
    parameter int unsigned ICL_PULSE_CYC = ftm_pkg::ICL_PULSE_CYC
) (
    input  wire logic       i_ref_clk,
    input  wire logic       i_rst_n,
    input  wire logic       i_ce,
    input  wire logic [7:0] i_cfg,
    input  wire logic       i_tach_input_a,
    input  wire logic       i_tach_input_b,
    input  wire logic [3:0] i_vid,
    input  wire logic       i_div_wr,
    input  wire logic [7:0] i_div_wdata,
    input  wire logic [7:0] i_lim_a,
    input  wire logic [7:0] i_lim_b,
    input  wire logic [2:0] i_mask,
    input  wire logic       i_stat_rd,
    input  wire logic       i_ciclr_wr,
    input  wire logic [7:0] i_ciclr_wdata,
    input  wire logic       i_intrusion_pin_in,
    output logic            o_intrusion_pin_out,
    output logic            o_intrusion_pin_oe,
    output logic [7:0]      o_fan_a_val,
    output logic [7:0]      o_fan_b_val,
    output logic [2:0]      o_status,
    output logic [7:0]      o_vid_div_rd,
    output logic [7:0]      o_ciclr_rd,
    output logic            o_analog_start,
    output logic            o_int_n
);
    typedef enum logic [2:0] {
        SQ_IDLE = 3'b001,
        SQ_A    = 3'b010,
        SQ_B    = 3'b100
    } ftm_sq_t;

    ftm_sq_t     sq_ff;
    logic [12:0] osc_ff;
    logic [3:0]  div_ff;
    logic [7:0]  val_a_ff;
    logic [7:0]  val_b_ff;
    logic [2:0]  stat_ff;
    logic        run_q_ff;
    logic        ast_ff;
    logic        ciclr_ff;
    logic [21:0] icl_cnt_ff;

    ftm_meas_if mif ();

    // Monitoring runs only with start set and output-clear low
    wire run      = i_cfg[ftm_pkg::CFG_START_BIT] & ~i_cfg[ftm_pkg::CFG_ICLR_BIT];
    wire int_on   = i_cfg[ftm_pkg::CFG_INTEN_BIT] & ~i_cfg[ftm_pkg::CFG_ICLR_BIT];
    wire osc_tick = (osc_ff == 13'(OSC_DIV_CYC - 1));
    wire upd_a    = i_ce && sq_ff == SQ_A && mif.done && run;
    wire upd_b    = i_ce && sq_ff == SQ_B && mif.done && run;
    wire go       = i_ce && run && ((sq_ff == SQ_IDLE) || mif.done);
    wire icl_end  = ciclr_ff && (icl_cnt_ff == 22'(ICL_PULSE_CYC - 1));
    wire icl_set  = i_ciclr_wr && i_ciclr_wdata[ftm_pkg::CICLR_BIT];
    wire over_a   = val_gt(mif.count, i_lim_a);
    wire over_b   = val_gt(mif.count, i_lim_b);
    wire [2:0] unmasked = stat_ff & ~i_mask;

    function automatic logic val_gt(input logic [7:0] v, input logic [7:0] lim);
        val_gt = v > lim;
    endfunction

    assign mif.go   = go;
    assign mif.tick = osc_tick;
    assign mif.tach = (sq_ff == SQ_B) ? i_tach_input_b : i_tach_input_a;
    assign mif.div  = (sq_ff == SQ_B) ? div_ff[3:2] : div_ff[1:0];

    ftm_tach_meas u_meas (
        .i_ref_clk (i_ref_clk),
        .i_rst_n   (i_rst_n),
        .i_ce      (i_ce),
        .m         (mif)
    );

    assign o_fan_a_val         = val_a_ff;
    assign o_fan_b_val         = val_b_ff;
    assign o_status            = stat_ff;
    assign o_vid_div_rd        = {div_ff, i_vid};
    assign o_ciclr_rd          = {ciclr_ff, 7'h00};
    assign o_analog_start      = ast_ff;
    assign o_intrusion_pin_out = 1'b0;
    assign o_intrusion_pin_oe  = ciclr_ff;
    assign o_int_n             = ~(int_on & (|unmasked));

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            osc_ff <= 13'h0000;
        end else if (i_ce) begin
            osc_ff <= osc_tick ? 13'h0000 : 13'(osc_ff + 13'h0001);
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            sq_ff    <= SQ_IDLE;
            run_q_ff <= 1'b0;
            ast_ff   <= 1'b0;
        end else if (i_ce) begin
            run_q_ff <= run;
            ast_ff   <= run & ~run_q_ff;
            if (!run) begin
                sq_ff <= SQ_IDLE;
            end else if (sq_ff == SQ_IDLE || (sq_ff == SQ_B && mif.done)) begin
                sq_ff <= SQ_A;
            end else if (sq_ff == SQ_A && mif.done) begin
                sq_ff <= SQ_B;
            end
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            div_ff   <= ftm_pkg::DIV_RST;
            val_a_ff <= 8'h00;
            val_b_ff <= 8'h00;
        end else if (i_ce) begin
            if (i_div_wr) begin
                div_ff <= i_div_wdata[7:4];
            end
            if (upd_a) begin
                val_a_ff <= mif.count;
            end
            if (upd_b) begin
                val_b_ff <= mif.count;
            end
        end
    end

    // A fresh update wins over a read clear in the same cycle
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            stat_ff <= 3'h0;
        end else if (i_ce) begin
            if (upd_a) begin
                stat_ff[ftm_pkg::ST_FAN_A] <= over_a;
            end else if (i_stat_rd) begin
                stat_ff[ftm_pkg::ST_FAN_A] <= 1'b0;
            end
            if (upd_b) begin
                stat_ff[ftm_pkg::ST_FAN_B] <= over_b;
            end else if (i_stat_rd) begin
                stat_ff[ftm_pkg::ST_FAN_B] <= 1'b0;
            end
            if (i_intrusion_pin_in) begin
                stat_ff[ftm_pkg::ST_INTR] <= 1'b1;
            end else if (i_stat_rd) begin
                stat_ff[ftm_pkg::ST_INTR] <= 1'b0;
            end
        end
    end

    // Long pulse keeps the pin low well past any latch reset time
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            ciclr_ff   <= 1'b0;
            icl_cnt_ff <= 22'h000000;
        end else if (i_ce) begin
            if (icl_set && !ciclr_ff) begin
                ciclr_ff   <= 1'b1;
                icl_cnt_ff <= 22'h000000;
            end else if (icl_end) begin
                ciclr_ff <= 1'b0;
            end else if (ciclr_ff) begin
                icl_cnt_ff <= 22'(icl_cnt_ff + 22'h000001);
            end
        end
    end

    property p_seq;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        upd_a |=> (sq_ff == SQ_B || !run) ##0 $past(mif.count) == val_a_ff;
    endproperty
    a_seq: assert property (p_seq) else $error("fan a result not stored");

    property p_cmp;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        upd_b |=> stat_ff[ftm_pkg::ST_FAN_B] == ($past(mif.count) > $past(i_lim_b));
    endproperty
    a_cmp: assert property (p_cmp) else $error("fan b limit compare wrong");

    property p_rdclr;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        (i_ce && i_stat_rd && !upd_a && !upd_b && !i_intrusion_pin_in) |=> stat_ff == 3'h0;
    endproperty
    a_rdclr: assert property (p_rdclr) else $error("status not cleared by read");

    property p_intr;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        (i_ce && i_intrusion_pin_in) |=> stat_ff[ftm_pkg::ST_INTR] && !o_int_n
            || i_mask[ftm_pkg::ST_INTR] || !int_on;
    endproperty
    a_intr: assert property (p_intr) else $error("intrusion level not held");

    property p_mask;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        (i_mask == 3'h7 || i_cfg[ftm_pkg::CFG_ICLR_BIT] || !i_cfg[ftm_pkg::CFG_INTEN_BIT])
            |-> o_int_n;
    endproperty
    a_mask: assert property (p_mask) else $error("interrupt with outputs gated");

    sequence s_icl_go;
        i_ce && icl_set && !ciclr_ff;
    endsequence
    property p_icl;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        s_icl_go |=> (o_intrusion_pin_oe && !o_intrusion_pin_out)[*8];
    endproperty
    a_icl: assert property (p_icl) else $error("intrusion pin not held low");

    property p_ast;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        (i_ce && run && !run_q_ff) |=> o_analog_start ##1 (!o_analog_start || !i_ce);
    endproperty
    a_ast: assert property (p_ast) else $error("analog start not pulsed");

    property p_divrst;
        @(posedge i_ref_clk)
        !i_rst_n |=> div_ff == 4'h5;
    endproperty
    a_divrst: assert property (p_divrst) else $error("divisor not two after reset");

    property p_upd_b;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        upd_b |=> sq_ff == SQ_A && val_b_ff == $past(mif.count);
    endproperty
    a_upd_b: assert property (p_upd_b) else $error("fan b result not stored");

    property p_cmp_a;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        upd_a |=> stat_ff[ftm_pkg::ST_FAN_A] == ($past(mif.count) > $past(i_lim_a));
    endproperty
    a_cmp_a: assert property (p_cmp_a) else $error("fan a limit compare wrong");

    // Values move only when a measurement finishes, so software never sees a partial count
    property p_val_hold;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        (i_ce && !upd_a && !upd_b) |=> $stable(val_a_ff) && $stable(val_b_ff);
    endproperty
    a_val_hold: assert property (p_val_hold) else $error("fan value moved without update");

    property p_idle;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        (i_ce && !run) |=> sq_ff == SQ_IDLE;
    endproperty
    a_idle: assert property (p_idle) else $error("sequencer ran while stopped");

    sequence s_first_go;
        i_ce && run && sq_ff == SQ_IDLE;
    endsequence
    property p_first_go;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        s_first_go |-> mif.go ##1 sq_ff == SQ_A;
    endproperty
    a_first_go: assert property (p_first_go) else $error("start did not launch fan a");

    sequence s_b_done;
        i_ce && run && sq_ff == SQ_B && mif.done;
    endsequence
    property p_wrap;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        s_b_done |-> mif.go ##1 sq_ff == SQ_A;
    endproperty
    a_wrap: assert property (p_wrap) else $error("fan b did not hand over to fan a");

    property p_divwr;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        (i_ce && i_div_wr) |=> div_ff == $past(i_div_wdata[7:4]);
    endproperty
    a_divwr: assert property (p_divwr) else $error("divisor write lost");

    property p_icl_end;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        (i_ce && icl_end) |=> !o_intrusion_pin_oe && o_ciclr_rd == 8'h00;
    endproperty
    a_icl_end: assert property (p_icl_end) else $error("clear bit did not self-clear");

    property p_icl_len;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        $fell(o_intrusion_pin_oe) |-> $past(icl_cnt_ff) == 22'(ICL_PULSE_CYC - 1);
    endproperty
    a_icl_len: assert property (p_icl_len) else $error("pull-down pulse too short");

    sequence s_icl_on;
        i_ce && o_intrusion_pin_oe && !icl_end;
    endsequence
    property p_icl_hold;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        s_icl_on |=> o_intrusion_pin_oe && !o_intrusion_pin_out;
    endproperty
    a_icl_hold: assert property (p_icl_hold) else $error("pull-down released early");

    property p_ast_once;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        (i_ce && o_analog_start) |=> !o_analog_start;
    endproperty
    a_ast_once: assert property (p_ast_once) else $error("analog start too long");

    property p_intr_wins;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        (i_ce && i_intrusion_pin_in && i_stat_rd) |=> stat_ff[ftm_pkg::ST_INTR];
    endproperty
    a_intr_wins: assert property (p_intr_wins) else $error("read cleared live intrusion");

    property p_rd_a;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        (i_ce && i_stat_rd && !upd_a) |=> !stat_ff[ftm_pkg::ST_FAN_A];
    endproperty
    a_rd_a: assert property (p_rd_a) else $error("fan a status survived read");
endmodule
